// ===== src/dea_pkg.sv
// Constants for the data EEPROM access controller.
// Assumes one 100 MHz clock and an 8-bit CPU data bus.
package dea_pkg;

   localparam logic [7:0] CSR_ADDR = 8'h30;
   localparam int PROGRAM_START_BIT = 0;
   localparam int LATCH_WRITE_MODE_BIT = 1;
   localparam logic [7:0] CSR_RESET = 8'h00;
   localparam logic [7:0] CSR_RSVD_MASK = 8'hFC;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] ERASED = 8'hFF;

   localparam int ADDR_W = 8;
   localparam int DEPTH = 256;
   localparam int ROW_BYTES = 32;
   localparam int COL_W = 5;
   localparam int ROW_W = 3;
   localparam logic [31:0] MASK_NONE = 32'h0000_0000;

   localparam int CLK_PERIOD_NS = 10;
   localparam int PROG_TIME_NS = 5000;
   localparam int PROG_CYCLES =
      (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 16;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;

   typedef enum logic [1:0] {
      DEA_IDLE = 2'b00,
      DEA_PROG = 2'b01,
      DEA_WAIT = 2'b10,
      DEA_HALT = 2'b11
   } dea_state_t;

endpackage

// ===== src/dea_array.sv
// EEPROM cell array: 256 bytes, row programming and mass erase.
// Assumes commit and erase are single-cycle pulses from the controller.
`timescale 1ns/10ps
module dea_array (
   input wire logic core_clk, // System clock
   input wire logic [7:0] rd_addr, // Read address
   output logic [7:0] rd_data, // Addressed byte, combinational
   input wire logic commit, // Program latched bytes into row
   input wire logic [2:0] commit_row, // Target row
   input wire logic [255:0] commit_data, // Latched bytes, col 0 low
   input wire logic [31:0] commit_mask, // Written columns
   input wire logic erase_all // Mass erase pulse
);

   logic [7:0] cells [dea_pkg::DEPTH];

   assign rd_data = cells[rd_addr];

   ////////////////////////////////////////////////////////////////////
   // Non-volatile contents, so no reset
   always_ff @(posedge core_clk) begin
      if (erase_all) begin
         for (int i = 0; i < dea_pkg::DEPTH; i++) begin
            cells[i] <= dea_pkg::ERASED;
         end
      end else if (commit) begin
         for (int i = 0; i < dea_pkg::ROW_BYTES; i++) begin
            if (commit_mask[i]) begin
               cells[{commit_row, i[dea_pkg::COL_W-1:0]}] <=
                  commit_data[i*8 +: 8];
            end
         end
      end
   end

endmodule

// ===== src/dea_ctrl.sv
// Data EEPROM access controller: read mode, row latches, timed
// programming, wait and halt handling, read-out protection.
// Assumes CPU accesses are one-cycle strobes synchronous to core_clk.
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module dea_ctrl #(
   parameter int PROG_CYCLES = dea_pkg::PROG_CYCLES
) (
   input wire logic core_clk, // System clock
   input wire logic rst_n, // Async reset, active low
   input wire logic [7:0] reg_addr, // Register address
   input wire logic [7:0] reg_wdata, // Register write data
   input wire logic reg_wr, // Register write strobe
   input wire logic reg_rd, // Register read strobe
   output logic [7:0] reg_rdata, // Register read data
   input wire logic [7:0] mem_addr, // EEPROM area byte address
   input wire logic [7:0] mem_wdata, // EEPROM write data
   input wire logic mem_wr, // EEPROM write strobe
   input wire logic mem_rd, // EEPROM read strobe
   input wire logic mem_fetch, // Read is an instruction fetch
   input wire logic mem_ext, // Access from external tool
   output logic [7:0] mem_rdata, // EEPROM read data
   output logic mem_drive, // Read data drives the bus
   output logic fetch_denied, // Fetch refused
   input wire logic wait_req, // Wait or active-halt request
   input wire logic halt_req, // Halt request
   output logic wait_ack, // In wait state
   output logic halt_ack, // In halt state
   input wire logic rop_enable, // Read-out protection option
   input wire logic rop_remove, // Protection removal pulse
   output logic prog_mem_erase, // Program memory erase pulse
   output logic prog_busy // Programming cycle running
);

   ////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic csr_hit(input logic [7:0] a);
      return a == dea_pkg::CSR_ADDR;
   endfunction

   function automatic logic [7:0] csr_pack(input logic l,
                                           input logic p);
      logic [7:0] v;
      v = dea_pkg::CSR_RESET;
      v[dea_pkg::LATCH_WRITE_MODE_BIT] = l;
      v[dea_pkg::PROGRAM_START_BIT] = p;
      return v;
   endfunction

   localparam logic [15:0] LAST_CNT = 16'(PROG_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////
   // State

   dea_pkg::dea_state_t state;
   dea_pkg::dea_state_t next_state;
   logic latch_write_mode;
   logic program_start;
   logic next_mode;
   logic next_start;
   logic [15:0] cnt;
   logic [7:0] col_data [dea_pkg::ROW_BYTES];
   logic [31:0] col_mask;
   logic [2:0] row_sel;
   logic [255:0] flat_data;
   logic [7:0] arr_rdata;
   logic csr_wr;
   logic prog_done;
   logic acc_ok;
   logic wr_ok;
   logic rd_ok;
   logic mode_fall;

   assign csr_wr = reg_wr && csr_hit(reg_addr);
   assign prog_done = state == dea_pkg::DEA_PROG
                      && cnt == LAST_CNT;
   assign acc_ok = !(rop_enable && mem_ext)
                   && state != dea_pkg::DEA_HALT;
   assign wr_ok = mem_wr && latch_write_mode && acc_ok;
   assign rd_ok = mem_rd && !latch_write_mode
                  && !mem_fetch && acc_ok;
   assign mode_fall = latch_write_mode && !next_mode;

   ////////////////////////////////////////////////////////////////////
   // Control/status bits

   always_comb begin
      next_mode = latch_write_mode;
      next_start = program_start;
      if (halt_req) begin
         next_mode = 1'b0;
         next_start = 1'b0;
      end else if (prog_done) begin
         next_mode = 1'b0;
         next_start = 1'b0;
      end else if (csr_wr) begin
         if (program_start) begin
            // Latch mode held; clearing start aborts
            next_start = reg_wdata[dea_pkg::PROGRAM_START_BIT];
         end else begin
            next_mode = reg_wdata[dea_pkg::LATCH_WRITE_MODE_BIT];
            next_start = reg_wdata[dea_pkg::PROGRAM_START_BIT]
                         && latch_write_mode && next_mode
                         && state == dea_pkg::DEA_IDLE && !wait_req;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         latch_write_mode <= 1'b0;
         program_start <= 1'b0;
      end else begin
         latch_write_mode <= next_mode;
         program_start <= next_start;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Power modes and programming sequence

   always_comb begin
      next_state = state;
      unique case (state)
         dea_pkg::DEA_IDLE: begin
            if (halt_req) begin
               next_state = dea_pkg::DEA_HALT;
            end else if (wait_req) begin
               next_state = dea_pkg::DEA_WAIT;
            end else if (next_start && !program_start) begin
               next_state = dea_pkg::DEA_PROG;
            end
         end
         dea_pkg::DEA_PROG: begin
            if (halt_req) begin
               next_state = dea_pkg::DEA_HALT;
            end else if (prog_done) begin
               next_state = wait_req ? dea_pkg::DEA_WAIT
                                     : dea_pkg::DEA_IDLE;
            end else if (!next_start) begin
               next_state = dea_pkg::DEA_IDLE;
            end
         end
         dea_pkg::DEA_WAIT: begin
            if (halt_req) begin
               next_state = dea_pkg::DEA_HALT;
            end else if (!wait_req) begin
               next_state = dea_pkg::DEA_IDLE;
            end
         end
         dea_pkg::DEA_HALT: begin
            if (!halt_req) begin
               next_state = dea_pkg::DEA_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= dea_pkg::DEA_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Cycle timer
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= dea_pkg::CNT_ZERO;
      end else if (state == dea_pkg::DEA_PROG
                   && next_state == dea_pkg::DEA_PROG) begin
         cnt <= cnt + dea_pkg::CNT_ONE;
      end else begin
         cnt <= dea_pkg::CNT_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Row latches

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < dea_pkg::ROW_BYTES; i++) begin
            col_data[i] <= dea_pkg::ERASED;
         end
         col_mask <= dea_pkg::MASK_NONE;
         row_sel <= '0;
      end else if (mode_fall) begin
         for (int i = 0; i < dea_pkg::ROW_BYTES; i++) begin
            col_data[i] <= dea_pkg::ERASED;
         end
         col_mask <= dea_pkg::MASK_NONE;
      end else if (wr_ok) begin
         col_data[mem_addr[dea_pkg::COL_W-1:0]] <=
            col_data[mem_addr[dea_pkg::COL_W-1:0]] & mem_wdata;
         col_mask[mem_addr[dea_pkg::COL_W-1:0]] <= 1'b1;
         row_sel <= mem_addr[dea_pkg::ADDR_W-1:dea_pkg::COL_W];
      end
   end

   always_comb begin
      flat_data = '0;
      for (int i = 0; i < dea_pkg::ROW_BYTES; i++) begin
         flat_data[i*8 +: 8] = col_data[i];
      end
   end

   dea_array u_dea_array (
      .core_clk(core_clk),
      .rd_addr(mem_addr),
      .rd_data(arr_rdata),
      .commit(prog_done),
      .commit_row(row_sel),
      .commit_data(flat_data),
      .commit_mask(col_mask),
      .erase_all(rop_remove)
   );

   ////////////////////////////////////////////////////////////////////
   // Bus answers; latches never reach the read mux

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_rdata <= dea_pkg::BYTE_ZERO;
         mem_drive <= 1'b0;
         fetch_denied <= 1'b0;
      end else begin
         mem_rdata <= rd_ok ? arr_rdata : dea_pkg::BYTE_ZERO;
         mem_drive <= rd_ok;
         fetch_denied <= mem_rd && mem_fetch;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= dea_pkg::CSR_RESET;
      end else if (reg_rd && csr_hit(reg_addr)) begin
         reg_rdata <= csr_pack(latch_write_mode, program_start);
      end else begin
         reg_rdata <= dea_pkg::BYTE_ZERO;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_ack <= 1'b0;
         halt_ack <= 1'b0;
         prog_busy <= 1'b0;
         prog_mem_erase <= 1'b0;
      end else begin
         wait_ack <= next_state == dea_pkg::DEA_WAIT;
         halt_ack <= next_state == dea_pkg::DEA_HALT;
         prog_busy <= next_start;
         prog_mem_erase <= rop_remove;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   a_done_clears_both: assert property (
      prog_done |=> !program_start && !latch_write_mode
                    && col_mask == dea_pkg::MASK_NONE)
      else $error("cycle end did not clear both bits");

   a_cycle_bounded: assert property (
      $rose(program_start) |-> ##[1:1000] !program_start)
      else $error("programming cycle never ended");

   a_read_in_latch: assert property (
      (mem_rd && latch_write_mode) |=> !mem_drive)
      else $error("bus driven in latch mode");

   a_read_served: assert property (
      (mem_rd && !latch_write_mode && !mem_fetch && !mem_ext
       && !halt_req && state != dea_pkg::DEA_HALT)
      |=> mem_drive && mem_rdata == $past(arr_rdata))
      else $error("read not answered next cycle");

   a_fetch_refused: assert property (
      (mem_rd && mem_fetch) |=> fetch_denied && !mem_drive)
      else $error("fetch served from eeprom");

   a_empty_read_mode: assert property (
      !latch_write_mode |-> col_mask == dea_pkg::MASK_NONE)
      else $error("latch filled in read mode");

   a_mode_clear_held: assert property (
      (program_start && csr_wr && !halt_req && !prog_done
       && !reg_wdata[dea_pkg::LATCH_WRITE_MODE_BIT])
      |=> latch_write_mode)
      else $error("latch mode cleared while programming");

   a_halt_abandons: assert property (
      halt_req |=> !program_start && halt_ack ##1 !prog_busy)
      else $error("halt did not stop programming");

   a_wait_when_idle: assert property (
      (state == dea_pkg::DEA_IDLE && wait_req && !halt_req)
      |=> wait_ack)
      else $error("idle wait not entered");

   a_wait_deferred: assert property (
      (state == dea_pkg::DEA_PROG && !prog_done && !halt_req)
      |=> !wait_ack)
      else $error("wait entered during programming");

   a_rsvd_zero: assert property (
      $past(reg_rd) |-> (reg_rdata & dea_pkg::CSR_RSVD_MASK)
                        == dea_pkg::BYTE_ZERO)
      else $error("reserved status bits set");

   a_protect_block: assert property (
      (mem_rd && mem_ext && rop_enable) |=> !mem_drive)
      else $error("protected read served");

   c_prog_done: cover property (
      $rose(program_start) ##[1:1000] prog_done);
   c_wait_after: cover property (
      prog_done && wait_req ##1 wait_ack);
   c_halt_abort: cover property (
      program_start && halt_req);
   c_and_rewrite: cover property (
      wr_ok && col_mask[mem_addr[dea_pkg::COL_W-1:0]]);

endmodule

// ===== testbench/dea_cpu_model.sv
// CPU core model: one-cycle register and EEPROM area strobes.
// Assumes the controller answers reads in the cycle after the strobe.
`timescale 1ns/10ps
module dea_cpu_model (
   input wire logic core_clk, // System clock
   output logic [7:0] reg_addr, // Register address
   output logic [7:0] reg_wdata, // Register write data
   output logic reg_wr, // Register write strobe
   output logic reg_rd, // Register read strobe
   input wire logic [7:0] reg_rdata, // Register read data
   output logic [7:0] mem_addr, // EEPROM byte address
   output logic [7:0] mem_wdata, // EEPROM write data
   output logic mem_wr, // EEPROM write strobe
   output logic mem_rd, // EEPROM read strobe
   output logic mem_fetch, // Read is a fetch
   output logic mem_ext, // External tool access
   input wire logic [7:0] mem_rdata, // EEPROM read data
   input wire logic mem_drive // Read data on bus
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      mem_addr = 8'h00;
      mem_wdata = 8'h00;
      mem_wr = 1'b0;
      mem_rd = 1'b0;
      mem_fetch = 1'b0;
      mem_ext = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic mem_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      mem_addr <= a;
      mem_wdata <= d;
      mem_wr <= 1'b1;
      @(posedge core_clk);
      mem_wr <= 1'b0;
   endtask
   task automatic mem_read(input logic [7:0] a, input logic f,
                           input logic x, output logic [7:0] d,
                           output logic drv);
      @(posedge core_clk);
      mem_addr <= a;
      mem_fetch <= f;
      mem_ext <= x;
      mem_rd <= 1'b1;
      @(posedge core_clk);
      mem_rd <= 1'b0;
      mem_fetch <= 1'b0;
      mem_ext <= 1'b0;
      #1;
      d = mem_rdata;
      drv = mem_drive;
   endtask
endmodule

// ===== testbench/test_data_eeprom_access_ctrl.sv
// Self-checking bench for the data EEPROM access controller.
// Assumes dea_ctrl and dea_array are compiled with dea_pkg.
`timescale 1ns/10ps
module test_data_eeprom_access_ctrl;
   localparam int PROG_N = 16;
   localparam logic [7:0] CSR = 8'h30;
   logic core_clk, rst_n, wait_req, halt_req, rop_enable, rop_remove;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, mem_addr, mem_wdata;
   logic [7:0] mem_rdata, d;
   logic reg_wr, reg_rd, mem_wr, mem_rd, mem_fetch, mem_ext, drv;
   logic mem_drive, fetch_denied, wait_ack, halt_ack;
   logic prog_mem_erase, prog_busy;
   int n_fail = 0;
   int samples_checked = 0;

   dea_ctrl #(.PROG_CYCLES(PROG_N)) u_dea_ctrl (.core_clk(core_clk),
      .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
      .mem_rd(mem_rd), .mem_fetch(mem_fetch), .mem_ext(mem_ext),
      .mem_rdata(mem_rdata), .mem_drive(mem_drive),
      .fetch_denied(fetch_denied), .wait_req(wait_req),
      .halt_req(halt_req), .wait_ack(wait_ack), .halt_ack(halt_ack),
      .rop_enable(rop_enable), .rop_remove(rop_remove),
      .prog_mem_erase(prog_mem_erase), .prog_busy(prog_busy));
   dea_cpu_model u_dea_cpu_model (.core_clk(core_clk),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd),
      .mem_fetch(mem_fetch), .mem_ext(mem_ext), .mem_rdata(mem_rdata),
      .mem_drive(mem_drive));

   always #5 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////////
   task automatic close_out();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk_byte(input string nm, input logic [7:0] e,
                           input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_bit(input string nm, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic csr_is(input logic [7:0] e);
      u_dea_cpu_model.reg_read(CSR, d);
      chk_byte("csr", e, d);
   endtask
   task automatic rd_is(input logic [7:0] a, input logic [7:0] e,
                        input logic de);
      u_dea_cpu_model.mem_read(a, 1'b0, 1'b0, d, drv);
      chk_bit("mem_drive", de, drv);
      chk_byte("mem_rdata", e, d);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      while (prog_busy !== 1'b0) begin
         @(posedge core_clk);
         #1;
         n++;
         if (n > PROG_N + 4) begin
            chk_bit("prog_busy timeout", 1'b0, prog_busy);
            close_out();
         end
      end
   endtask
   task automatic load_row(input logic [7:0] a, input logic [7:0] v);
      u_dea_cpu_model.reg_write(CSR, 8'h02);
      u_dea_cpu_model.mem_write(a, v);
      u_dea_cpu_model.reg_write(CSR, 8'h03);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      rst_n = 1'b0;
      wait_req = 1'b0;
      halt_req = 1'b0;
      rop_enable = 1'b0;
      rop_remove = 1'b0;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      csr_is(8'h00);
      chk_bit("prog_busy", 1'b0, prog_busy);
      u_dea_cpu_model.reg_read(8'h31, d);
      chk_byte("unmapped", 8'h00, d);
      @(posedge core_clk);
      rop_remove <= 1'b1;
      @(posedge core_clk);
      rop_remove <= 1'b0;
      #1;
      chk_bit("prog_mem_erase", 1'b1, prog_mem_erase);
      rd_is(8'h25, 8'hFF, 1'b1);
      u_dea_cpu_model.mem_write(8'h24, 8'h00);
      u_dea_cpu_model.reg_write(CSR, 8'hFE);
      csr_is(8'h02);
      u_dea_cpu_model.mem_write(8'h21, 8'h5A);
      u_dea_cpu_model.mem_write(8'h22, 8'hF3);
      u_dea_cpu_model.mem_write(8'h22, 8'h3C);
      rd_is(8'h21, 8'h00, 1'b0);
      u_dea_cpu_model.reg_write(CSR, 8'h03);
      csr_is(8'h03);
      chk_bit("prog_busy", 1'b1, prog_busy);
      u_dea_cpu_model.reg_write(CSR, 8'h01);
      csr_is(8'h03);
      wait_idle();
      csr_is(8'h00);
      rd_is(8'h21, 8'h5A, 1'b1);
      rd_is(8'h22, 8'h30, 1'b1);
      rd_is(8'h23, 8'hFF, 1'b1);
      rd_is(8'h24, 8'hFF, 1'b1);
      // Wait request held off by a running cycle
      load_row(8'h40, 8'h11);
      @(posedge core_clk);
      wait_req <= 1'b1;
      @(posedge core_clk);
      #1;
      chk_bit("wait_ack busy", 1'b0, wait_ack);
      wait_idle();
      @(posedge core_clk);
      #1;
      chk_bit("wait_ack after", 1'b1, wait_ack);
      @(posedge core_clk);
      wait_req <= 1'b0;
      repeat (2) @(posedge core_clk);
      rd_is(8'h40, 8'h11, 1'b1);
      @(posedge core_clk);
      wait_req <= 1'b1;
      @(posedge core_clk);
      #1;
      chk_bit("wait_ack idle", 1'b1, wait_ack);
      @(posedge core_clk);
      wait_req <= 1'b0;
      // Halt abandons programming at once
      load_row(8'h60, 8'h00);
      @(posedge core_clk);
      halt_req <= 1'b1;
      @(posedge core_clk);
      #1;
      chk_bit("halt_ack", 1'b1, halt_ack);
      chk_bit("prog_busy halt", 1'b0, prog_busy);
      @(posedge core_clk);
      halt_req <= 1'b0;
      repeat (2) @(posedge core_clk);
      csr_is(8'h00);
      // Software abort keeps latch mode, then latch mode is left
      load_row(8'h60, 8'h00);
      u_dea_cpu_model.reg_write(CSR, 8'h02);
      csr_is(8'h02);
      chk_bit("prog_busy abort", 1'b0, prog_busy);
      u_dea_cpu_model.reg_write(CSR, 8'h00);
      csr_is(8'h00);
      u_dea_cpu_model.mem_read(8'h21, 1'b1, 1'b0, d, drv);
      chk_bit("fetch drive", 1'b0, drv);
      chk_bit("fetch_denied", 1'b1, fetch_denied);
      rop_enable <= 1'b1;
      u_dea_cpu_model.mem_read(8'h21, 1'b0, 1'b1, d, drv);
      chk_bit("ext drive", 1'b0, drv);
      rd_is(8'h21, 8'h5A, 1'b1);
      close_out();
   end
endmodule
